//--- hw/mhb_host_bus.sv
// Notes on behaviour
// - Low address and data share one 8-bit bidirectional bus, time-multiplexed.
// - A separate output byte carries address bits eight to fifteen.
// - Four bus operations; only the extended ones update the upper byte.
// - Mode value 8 enters emulation; value 0 resets out of it.
// - In emulation both channels' pins act as one bus interface.
// - First auxiliary pin is GPIO, set, cleared or read by command.
// - Wait commands stall processing until the irq pin is high or low.
// - After the interrupt level, the queued read runs and returns its byte.
// - Wait input low lengthens cycles; it is held high when unused.
// - A monitor pin shows the clock the bus logic runs from; here it shows it divided by twice MON_HALF_PERIOD.
// - Latch strobe pulses high; active-low select pulses each cycle.
// - Write latch strobe is one clock, two if wait is low.
// - Data leads write strobe by a clock; strobe six clocks if waiting.
// - Select releases half a clock after write strobe; data held till then.
`timescale 1ns/100ps
`include "mhb_regs.svh"
module mhb_host_bus #(
  parameter int MON_HALF_PERIOD = 1
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Mode selection
  input  wire logic              mode_sel_valid,
  input  wire mhb_pkg::mhb_byte_t mode_sel_value,
  output logic                   mode_active,
  // Command port
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire mhb_pkg::mhb_op_e  cmd_op,
  input  wire logic       [15:0] cmd_addr,
  input  wire mhb_pkg::mhb_byte_t cmd_wdata,
  // Answer port
  output logic                   rsp_valid,
  output mhb_pkg::mhb_byte_t     rsp_data,
  // Multiplexed address and data bus
  input  wire mhb_pkg::mhb_byte_t muxed_bus_in,
  output mhb_pkg::mhb_byte_t     muxed_bus_out,
  output logic                   muxed_bus_oe,
  // Upper address and strobes
  output mhb_pkg::mhb_byte_t     upper_addr_out,
  output logic                   ale_out,
  output logic                   cs_n_out,
  output logic                   rd_n_out,
  output logic                   wr_n_out,
  input  wire logic              wait_extend_in,
  // Auxiliary pins
  input  wire logic              aux_pin_first_in,
  output logic                   aux_pin_first_out,
  output logic                   aux_pin_first_oe,
  input  wire logic              irq_wait_pin_in,
  output logic                   irq_wait_pin_out,
  output logic                   irq_wait_pin_oe,
  // Clock monitor
  output logic                   clock_monitor_out
);
  import mhb_pkg::*;

  mhb_state_e state_r;
  mhb_state_e state_nxt;
  mhb_op_e    op_r;
  mhb_op_e    op_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       ext_r;
  logic       ext_nxt;
  mhb_byte_t  wdata_r;
  mhb_byte_t  wdata_nxt;
  mhb_byte_t  bus_out_nxt;
  logic       bus_oe_nxt;
  mhb_byte_t  upper_nxt;
  logic       ale_nxt;
  logic       cs_n_r;
  logic       cs_n_nxt;
  logic       rd_n_nxt;
  logic       wr_n_nxt;
  logic       rsp_valid_nxt;
  mhb_byte_t  rsp_data_nxt;
  logic       mode_nxt;
  logic       ready_nxt;
  logic [1:0] aux_out;
  logic [1:0] aux_oe;

  function automatic logic op_is_write(input mhb_op_e op);
    op_is_write = (op == MHB_OP_WRITE) || (op == MHB_OP_WRITE_EXT);
  endfunction : op_is_write

  function automatic logic op_is_bus(input mhb_op_e op);
    op_is_bus = (op == MHB_OP_READ) || (op == MHB_OP_READ_EXT) ||
                op_is_write(op);
  endfunction : op_is_bus

  // Decoding of the mode command and of the incoming command.
  wire mode_enter  = mode_sel_valid &&
                     (mode_sel_value == `MHB_MODE_EMULATION);
  wire mode_leave  = mode_sel_valid && !mode_enter;
  wire accept      = cmd_valid && cmd_ready && !mode_sel_valid;
  wire is_ext      = (cmd_op == MHB_OP_READ_EXT) ||
                     (cmd_op == MHB_OP_WRITE_EXT);
  wire aux_set     = accept && (cmd_op == MHB_OP_SET_AUX);
  wire aux_get     = accept && (cmd_op == MHB_OP_GET_AUX);
  wire ale_last    = ext_r ? (cnt_r == `MHB_ALE_EXT_CLK - 3'h1)
                           : (cnt_r == `MHB_ALE_CLK - 3'h1);
  wire strobe_last = ext_r ? (cnt_r == `MHB_STROBE_EXT_CLK - 3'h1)
                           : (cnt_r == `MHB_STROBE_CLK - 3'h1);
  wire level_hit   = (irq_wait_pin_in == (op_r == MHB_OP_WAIT_HIGH));
  wire mhb_byte_t aux_read = {6'h00, irq_wait_pin_in, aux_pin_first_in};

  always_comb begin
    state_nxt     = state_r;
    op_nxt        = op_r;
    cnt_nxt       = cnt_r;
    ext_nxt       = ext_r;
    wdata_nxt     = wdata_r;
    bus_out_nxt   = muxed_bus_out;
    bus_oe_nxt    = muxed_bus_oe;
    upper_nxt     = upper_addr_out;
    ale_nxt       = ale_out;
    cs_n_nxt      = cs_n_r;
    rd_n_nxt      = rd_n_out;
    wr_n_nxt      = wr_n_out;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt  = rsp_data;
    mode_nxt      = mode_active;
    case (state_r)
      MHB_ST_IDLE: begin
        if (accept) begin
          op_nxt    = cmd_op;
          wdata_nxt = cmd_wdata;
          if (is_ext) begin
            upper_nxt = cmd_addr[15:8];
          end
          if (op_is_bus(cmd_op)) begin
            bus_out_nxt = cmd_addr[7:0];
            bus_oe_nxt  = 1'b1;
            cnt_nxt     = 3'h0;
            state_nxt   = MHB_ST_ADDR;
          end else if ((cmd_op == MHB_OP_WAIT_HIGH) ||
                       (cmd_op == MHB_OP_WAIT_LOW)) begin
            state_nxt = MHB_ST_WAIT;
          end
        end
        if (aux_get) begin
          rsp_valid_nxt = 1'b1;
          rsp_data_nxt  = aux_read;
        end
      end
      MHB_ST_ADDR: begin
        if (cnt_r == `MHB_ADDR_SETUP_CLK - 3'h1) begin
          ale_nxt   = 1'b1;
          ext_nxt   = !wait_extend_in;
          cnt_nxt   = 3'h0;
          state_nxt = MHB_ST_ALE;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      MHB_ST_ALE: begin
        if (ale_last) begin
          ale_nxt  = 1'b0;
          cs_n_nxt = 1'b0;
          cnt_nxt  = 3'h0;
          if (op_is_write(op_r)) begin
            bus_out_nxt = wdata_r;
          end else begin
            bus_oe_nxt = 1'b0;
          end
          state_nxt = MHB_ST_SETUP;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      MHB_ST_SETUP: begin
        if (cnt_r == `MHB_DATA_SETUP_CLK - 3'h1) begin
          if (op_is_write(op_r)) begin
            wr_n_nxt = 1'b0;
          end else begin
            rd_n_nxt = 1'b0;
          end
          ext_nxt   = !wait_extend_in;
          cnt_nxt   = 3'h0;
          state_nxt = MHB_ST_STROBE;
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      MHB_ST_STROBE: begin
        if (strobe_last) begin
          wr_n_nxt  = 1'b1;
          rd_n_nxt  = 1'b1;
          // The select flop here is retimed on the falling edge below,
          // which gives the half-clock release after the strobe.
          cs_n_nxt  = 1'b1;
          state_nxt = MHB_ST_HOLD;
          if (!op_is_write(op_r)) begin
            rsp_valid_nxt = 1'b1;
            rsp_data_nxt  = muxed_bus_in;
          end
        end else begin
          cnt_nxt = cnt_r + 3'h1;
        end
      end
      MHB_ST_HOLD: begin
        bus_oe_nxt = 1'b0;
        state_nxt  = MHB_ST_IDLE;
      end
      MHB_ST_WAIT: begin
        if (level_hit) begin
          state_nxt = MHB_ST_IDLE;
        end
      end
      default: begin
        state_nxt = MHB_ST_IDLE;
      end
    endcase
    if (mode_enter) begin
      mode_nxt = 1'b1;
    end
    if (mode_leave) begin
      // Leaving the mode abandons any cycle and parks every pin but the clock monitor.
      mode_nxt      = 1'b0;
      state_nxt     = MHB_ST_IDLE;
      bus_oe_nxt    = 1'b0;
      bus_out_nxt   = 8'h00;
      upper_nxt     = `MHB_UPPER_RST;
      ale_nxt       = 1'b0;
      cs_n_nxt      = 1'b1;
      rd_n_nxt      = 1'b1;
      wr_n_nxt      = 1'b1;
      rsp_valid_nxt = 1'b0;
    end
  end

  assign ready_nxt = mode_nxt && (state_nxt == MHB_ST_IDLE) &&
                     !(accept && op_is_bus(cmd_op));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= MHB_ST_IDLE;
      op_r    <= MHB_OP_READ;
      cnt_r   <= 3'h0;
      ext_r   <= 1'b0;
      wdata_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      ext_r   <= ext_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      muxed_bus_out  <= 8'h00;
      muxed_bus_oe   <= 1'b0;
      upper_addr_out <= `MHB_UPPER_RST;
      ale_out        <= 1'b0;
      cs_n_r         <= 1'b1;
      rd_n_out       <= 1'b1;
      wr_n_out       <= 1'b1;
    end else begin
      muxed_bus_out  <= bus_out_nxt;
      muxed_bus_oe   <= bus_oe_nxt;
      upper_addr_out <= upper_nxt;
      ale_out        <= ale_nxt;
      cs_n_r         <= cs_n_nxt;
      rd_n_out       <= rd_n_nxt;
      wr_n_out       <= wr_n_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_valid   <= 1'b0;
      rsp_data    <= 8'h00;
      mode_active <= 1'b0;
      cmd_ready   <= 1'b0;
    end else begin
      rsp_valid   <= rsp_valid_nxt;
      rsp_data    <= rsp_data_nxt;
      mode_active <= mode_nxt;
      cmd_ready   <= ready_nxt;
    end
  end

  // Select moves half a clock after its rising-edge source.
  always_ff @(negedge clk_sys or posedge rst) begin
    if (rst) begin
      cs_n_out <= 1'b1;
    end else begin
      cs_n_out <= cs_n_r;
    end
  end

  mhb_aux_pins u_aux (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clear   (mode_leave),
    .set_stb (aux_set),
    .set_val (cmd_wdata[1:0]),
    .set_dir (cmd_addr[1:0]),
    .pin_out (aux_out),
    .pin_oe  (aux_oe)
  );

  assign aux_pin_first_out = aux_out[`MHB_AUX_FIRST_BIT];
  assign aux_pin_first_oe  = aux_oe[`MHB_AUX_FIRST_BIT];
  assign irq_wait_pin_out  = aux_out[`MHB_AUX_IRQ_BIT];
  assign irq_wait_pin_oe   = aux_oe[`MHB_AUX_IRQ_BIT];

  mhb_clk_mon #(
    .HALF_PERIOD (MON_HALF_PERIOD)
  ) u_mon (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .clock_monitor_out (clock_monitor_out)
  );

endmodule : mhb_host_bus

//--- hw/mhb_regs.svh
`ifndef MHB_REGS_SVH
`define MHB_REGS_SVH

// Mode selection values carried by the bit-mode command.
`define MHB_MODE_EMULATION  8'h08
`define MHB_MODE_RESET      8'h00

// Bus cycle timing in clk_sys cycles.
`define MHB_ADDR_SETUP_CLK  3'h1
`define MHB_ALE_CLK         3'h1
`define MHB_ALE_EXT_CLK     3'h2
`define MHB_DATA_SETUP_CLK  3'h1
`define MHB_STROBE_CLK      3'h1
`define MHB_STROBE_EXT_CLK  3'h6

// Reset values.
`define MHB_UPPER_RST       8'h00
`define MHB_AUX_RST         2'h0

// Field positions inside the auxiliary pin byte.
`define MHB_AUX_FIRST_BIT   0
`define MHB_AUX_IRQ_BIT     1

`endif

//--- hw/mhb_pkg.sv
package mhb_pkg;

  typedef enum logic [2:0] {
    MHB_OP_READ,
    MHB_OP_READ_EXT,
    MHB_OP_WRITE,
    MHB_OP_WRITE_EXT,
    MHB_OP_WAIT_HIGH,
    MHB_OP_WAIT_LOW,
    MHB_OP_SET_AUX,
    MHB_OP_GET_AUX
  } mhb_op_e;

  typedef enum logic [2:0] {
    MHB_ST_IDLE,
    MHB_ST_ADDR,
    MHB_ST_ALE,
    MHB_ST_SETUP,
    MHB_ST_STROBE,
    MHB_ST_HOLD,
    MHB_ST_WAIT
  } mhb_state_e;

  typedef logic [7:0] mhb_byte_t;

endpackage : mhb_pkg

//--- hw/mhb_clk_mon.sv
`timescale 1ns/100ps
module mhb_clk_mon #(
  parameter int HALF_PERIOD = 1
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Monitor pin
  output logic      clock_monitor_out
);
  import mhb_pkg::*;

  // A flop cannot pass the clock itself, so the pin shows it divided by twice HALF_PERIOD.
  logic [7:0] cnt_r;
  wire        wrap = (cnt_r == 8'(HALF_PERIOD - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r             <= 8'h00;
      clock_monitor_out <= 1'b0;
    end else begin
      cnt_r             <= wrap ? 8'h00 : cnt_r + 8'h01;
      clock_monitor_out <= wrap ? ~clock_monitor_out : clock_monitor_out;
    end
  end

endmodule : mhb_clk_mon

//--- hw/mhb_aux_pins.sv
`timescale 1ns/100ps
`include "mhb_regs.svh"
module mhb_aux_pins (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control from the bus engine
  input  wire logic       clear,
  input  wire logic       set_stb,
  input  wire logic [1:0] set_val,
  input  wire logic [1:0] set_dir,
  // Pin drive
  output logic      [1:0] pin_out,
  output logic      [1:0] pin_oe
);
  import mhb_pkg::*;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          pin_out[g] <= 1'b0;
          pin_oe[g]  <= 1'b0;
        end else if (clear) begin
          pin_out[g] <= 1'b0;
          pin_oe[g]  <= 1'b0;
        end else if (set_stb) begin
          pin_out[g] <= set_val[g];
          pin_oe[g]  <= set_dir[g];
        end
      end
    end
  endgenerate

endmodule : mhb_aux_pins

//--- tb/mhb_host_bus_properties.sv
`timescale 1ns/100ps
`include "mhb_regs.svh"
module mhb_host_bus_checker
  import mhb_pkg::*;
#(
  parameter int MON_HALF_PERIOD = 1
) (
  input wire logic      clk_sys,
  input wire logic      rst,
  input wire logic      mode_sel_valid,
  input wire mhb_byte_t mode_sel_value,
  input wire logic      mode_active,
  input wire logic      cmd_valid,
  input wire logic      cmd_ready,
  input wire mhb_op_e   cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic      rsp_valid,
  input wire mhb_byte_t rsp_data,
  input wire mhb_byte_t muxed_bus_out,
  input wire logic      muxed_bus_oe,
  input wire mhb_byte_t upper_addr_out,
  input wire logic      ale_out,
  input wire logic      cs_n_out,
  input wire logic      rd_n_out,
  input wire logic      wr_n_out,
  input wire logic      clock_monitor_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire       acc = cmd_valid && cmd_ready && !mode_sel_valid;
  wire       ext = cmd_op == MHB_OP_READ_EXT || cmd_op == MHB_OP_WRITE_EXT;
  wire       rdo = cmd_op == MHB_OP_READ || cmd_op == MHB_OP_READ_EXT;
  wire       pln = cmd_op == MHB_OP_READ || cmd_op == MHB_OP_WRITE;
  logic [7:0] up_r;
  // Upper byte of the last accepted command, for the extended-op check.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) up_r <= 8'h00;
    else if (acc) up_r <= cmd_addr[15:8];
  end
  sequence s_wr_short; ##1 wr_n_out; endsequence
  sequence s_wr_long; !wr_n_out[*6] ##1 wr_n_out; endsequence
  property p_wr_width; $fell(wr_n_out) |-> s_wr_short or s_wr_long;
  endproperty
  a_wr_width: assert property (p_wr_width)
    else $error("write strobe width wrong");
  property p_wr_setup;
    $fell(wr_n_out) |-> muxed_bus_oe && $stable(muxed_bus_out) && !cs_n_out;
  endproperty
  a_wr_setup: assert property (p_wr_setup)
    else $error("write data not set up");
  property p_cs_rel; $rose(wr_n_out) && mode_active |->
    cs_n_out && muxed_bus_oe && $stable(muxed_bus_out); endproperty
  a_cs_rel: assert property (p_cs_rel)
    else $error("select release or data hold wrong");
  property p_ale; $rose(ale_out) |-> ##[1:2] !ale_out; endproperty
  a_ale: assert property (p_ale)
    else $error("latch strobe width wrong");
  property p_ale_cs; $fell(ale_out) |-> !cs_n_out; endproperty
  a_ale_cs: assert property (p_ale_cs)
    else $error("select not active after latch");
  property p_rd_bus; $fell(rd_n_out) |-> !muxed_bus_oe && !cs_n_out;
  endproperty
  a_rd_bus: assert property (p_rd_bus)
    else $error("bus still driven in read");
  property p_up_ext; acc && ext |-> ##2 upper_addr_out == up_r; endproperty
  a_up_ext: assert property (p_up_ext)
    else $error("upper byte not updated");
  property p_up_plain; acc && pln |=> $stable(upper_addr_out)[*5];
  endproperty
  a_up_plain: assert property (p_up_plain)
    else $error("upper byte changed by plain op");
  property p_rd_lat; acc && rdo |-> (##5 rsp_valid) or (##11 rsp_valid);
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_aux_rsp; acc && cmd_op == MHB_OP_GET_AUX |->
    ##1 rsp_valid && rsp_data[7:2] == 6'h00; endproperty
  a_aux_rsp: assert property (p_aux_rsp)
    else $error("pin read answer wrong");
  property p_mode_on; mode_sel_valid &&
    mode_sel_value == `MHB_MODE_EMULATION |=> mode_active && cmd_ready;
  endproperty
  a_mode_on: assert property (p_mode_on)
    else $error("mode not entered");
  property p_mode_off; mode_sel_valid && mode_sel_value != 8'h08 |=>
    !mode_active && !cmd_ready && upper_addr_out == 8'h00; endproperty
  a_mode_off: assert property (p_mode_off)
    else $error("mode not left");
  property p_mon; MON_HALF_PERIOD == 1 && !$past(rst) && !$past(rst, 2)
    |-> clock_monitor_out != $past(clock_monitor_out); endproperty
  a_mon: assert property (p_mon)
    else $error("monitor clock stuck");
endmodule : mhb_host_bus_checker
bind mhb_host_bus mhb_host_bus_checker #(
  .MON_HALF_PERIOD(MON_HALF_PERIOD)
) chk_u (.clk_sys, .rst, .mode_sel_valid, .mode_sel_value, .mode_active,
  .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .rsp_valid, .rsp_data,
  .muxed_bus_out, .muxed_bus_oe, .upper_addr_out, .ale_out, .cs_n_out,
  .rd_n_out, .wr_n_out, .clock_monitor_out);

//--- tb/mhb_periph_model.sv
`timescale 1ns/100ps
module mhb_periph_model (
  // Bus from the block
  input  wire mhb_pkg::mhb_byte_t muxed_bus_out,
  input  wire mhb_pkg::mhb_byte_t upper_addr_out,
  input  wire logic               ale_out,
  input  wire logic               cs_n_out,
  input  wire logic               rd_n_out,
  input  wire logic               wr_n_out,
  input  wire logic               slow,
  // Answers to the block
  output mhb_pkg::mhb_byte_t      muxed_bus_in,
  output logic                    wait_extend_in
);
  import mhb_pkg::*;
  mhb_byte_t   mem [logic [15:0]];
  mhb_byte_t   rd_data;
  logic [15:0] addr_r;
  // The address is taken as the latch strobe rises, because the block
  // swaps the bus to write data on the very edge that drops the strobe.
  always @(posedge ale_out) begin
    addr_r = {upper_addr_out, muxed_bus_out};
  end
  always @(posedge wr_n_out) if (!cs_n_out) mem[addr_r] = muxed_bus_out;
  always @(negedge rd_n_out) rd_data = mem[addr_r];
  // Outside a selected read the pull-ups take the lines high.
  assign muxed_bus_in = (!rd_n_out && !cs_n_out) ? rd_data : 8'hFF;
  assign wait_extend_in = !slow;
endmodule : mhb_periph_model

//--- tb/mhb_host_bus_tb.sv
`timescale 1ns/100ps
module mhb_host_bus_tb;
  import mhb_pkg::*;
  logic        clk_sys, rst, mode_sel_valid, cmd_valid, slow, aux_ext, irq_ext;
  logic        mode_active, cmd_ready, rsp_valid, muxed_bus_oe, ale_out;
  logic        cs_n_out, rd_n_out, wr_n_out, wait_extend_in, clock_monitor_out;
  logic        aux_pin_first_out, aux_pin_first_oe, irq_wait_pin_out;
  logic        irq_wait_pin_oe;
  mhb_byte_t   mode_sel_value, cmd_wdata, rsp_data, muxed_bus_in;
  mhb_byte_t   muxed_bus_out, upper_addr_out, up_exp;
  mhb_op_e     cmd_op;
  logic [15:0] cmd_addr, last_a;
  mhb_byte_t   shadow [logic [15:0]];
  mhb_byte_t   exp_q [$];
  int          errors, comparisons;
  // Released pins take the levels that the bench drives on aux_ext and irq_ext.
  wire aux_pin_first_in = aux_pin_first_oe ? aux_pin_first_out : aux_ext;
  wire irq_wait_pin_in = irq_wait_pin_oe ? irq_wait_pin_out : irq_ext;
  mhb_host_bus dut_u (.clk_sys, .rst, .mode_sel_valid, .mode_sel_value,
    .mode_active, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_wdata,
    .rsp_valid, .rsp_data, .muxed_bus_in, .muxed_bus_out, .muxed_bus_oe,
    .upper_addr_out, .ale_out, .cs_n_out, .rd_n_out, .wr_n_out,
    .wait_extend_in, .aux_pin_first_in, .aux_pin_first_out,
    .aux_pin_first_oe, .irq_wait_pin_in, .irq_wait_pin_out,
    .irq_wait_pin_oe, .clock_monitor_out);
  mhb_periph_model per_u (.muxed_bus_out, .upper_addr_out, .ale_out,
    .cs_n_out, .rd_n_out, .wr_n_out, .slow, .muxed_bus_in, .wait_extend_in);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic complete_run();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic chk8(input mhb_byte_t got, input mhb_byte_t exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask : chk1
  task automatic mode(input mhb_byte_t v);
    @(negedge clk_sys);
    mode_sel_valid = 1'b1;
    mode_sel_value = v;
    @(negedge clk_sys);
    mode_sel_valid = 1'b0;
    chk1(mode_active, v == 8'h08);
  endtask : mode
  task automatic issue(input mhb_op_e op, input logic [15:0] a,
                       input mhb_byte_t d);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && n < 500) begin
      n++;
      @(negedge clk_sys);
    end
    if (n >= 500) errors++;
    cmd_op = op;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
  endtask : issue
  // Plain ops reuse the upper byte left by the last extended op.
  task automatic bus(input mhb_op_e op, input logic [15:0] a);
    logic      ext;
    mhb_byte_t d;
    ext = op == MHB_OP_READ_EXT || op == MHB_OP_WRITE_EXT;
    d = 8'($urandom);
    if (ext) up_exp = a[15:8];
    last_a = {up_exp, a[7:0]};
    if (op == MHB_OP_WRITE || op == MHB_OP_WRITE_EXT) shadow[last_a] = d;
    else exp_q.push_back(shadow[last_a]);
    issue(op, a, d);
    repeat (3) @(negedge clk_sys);
    chk8(upper_addr_out, up_exp);
  endtask : bus
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      chk1(exp_q.size() > 0, 1'b1);
      if (exp_q.size() > 0) chk8(rsp_data, exp_q.pop_front());
    end
  end
  initial begin
    logic [15:0] a;
    {rst, mode_sel_valid, cmd_valid, slow, aux_ext, irq_ext} = 6'h23;
    {mode_sel_value, cmd_wdata, cmd_addr, up_exp} = 40'h00_0000_0000;
    cmd_op = MHB_OP_READ;
    errors = 0;
    comparisons = 0;
    void'($urandom(32'h166d));
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    chk1(cmd_ready, 1'b0);
    mode(8'h08);
    for (int s = 0; s < 6; s++) begin
      slow = s[0];
      a = 16'($urandom);
      bus(MHB_OP_WRITE_EXT, a);
      bus(MHB_OP_WRITE, a ^ 16'h5501);
      bus(MHB_OP_READ_EXT, a);
      bus(MHB_OP_READ, a ^ 16'h5501);
    end
    for (int i = 0; i < 2; i++) begin
      irq_ext = i[0];
      issue(i[0] ? MHB_OP_WAIT_LOW : MHB_OP_WAIT_HIGH, 16'h0000, 8'h00);
      repeat (20) @(negedge clk_sys);
      chk1(cmd_ready, 1'b0);
      irq_ext = !i[0];
      bus(MHB_OP_READ_EXT, last_a);
    end
    for (int v = 0; v < 4; v++) begin
      // The irq pin stays an input: direction bit one is kept clear.
      issue(MHB_OP_SET_AUX, 16'h0001, {7'h0, v[0]});
      chk1(aux_pin_first_oe, 1'b1);
      chk1(aux_pin_first_out, v[0]);
      chk1(irq_wait_pin_oe, 1'b0);
      exp_q.push_back({6'h00, irq_ext, v[0]});
      issue(MHB_OP_GET_AUX, 16'h0000, 8'h00);
    end
    repeat (20) @(negedge clk_sys);
    mode(8'h00);
    chk8(upper_addr_out, 8'h00);
    chk1(aux_pin_first_oe, 1'b0);
    chk1(cmd_ready, 1'b0);
    chk1(exp_q.size() == 0, 1'b1);
    complete_run();
  end
  initial begin
    #50us;
    errors++;
    complete_run();
  end
endmodule : mhb_host_bus_tb
